// *** rtc_enable_pkg.sv ***
// constants for the counter's interrupt and event-route enable registers
// assumes a 12-bit byte address on a plain strobe register port
package rtc_enable_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NUM_EVT = 6;

  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE_SET = 12'h304;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE_CLEAR = 12'h308;
  localparam logic [ADDR_W-1:0] OFS_EVENT_ROUTE_ENABLE = 12'h340;
  localparam logic [ADDR_W-1:0] OFS_EVENT_ROUTE_SET = 12'h344;
  localparam logic [ADDR_W-1:0] OFS_EVENT_ROUTE_CLEAR = 12'h348;
  localparam logic [ADDR_W-1:0] OFS_EVENT_STATUS = 12'h380;

  localparam int FLD_TICK = 0;
  localparam int FLD_COUNTER_WRAP = 1;
  localparam int FLD_COMPARE0 = 2;
  localparam int FLD_COMPARE1 = 3;
  localparam int FLD_COMPARE2 = 4;
  localparam int FLD_COMPARE3 = 5;

  localparam logic [NUM_EVT-1:0] RST_ENABLE = 6'h00;
  localparam logic [NUM_EVT-1:0] RST_STATUS = 6'h00;
  localparam logic [DATA_W-1:0] RD_UNMAPPED = 32'h0000_0000;

endpackage

// *** enable_bank.sv ***
// one six-bit enable mask with optional direct write, set and clear ports
// assumes at most one of the write strobes is high in a cycle
`timescale 1ns/1ps
`default_nettype none
module enable_bank
  import rtc_enable_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wrDirect,
  input wire logic wrSet,
  input wire logic wrClr,
  input wire logic [NUM_EVT-1:0] wrData,
  output logic [NUM_EVT-1:0] mask
);

  logic [NUM_EVT-1:0] mask_q;
  logic [NUM_EVT-1:0] mask_d;

  always_comb begin
    mask_d = mask_q;
    if (wrDirect) begin
      mask_d = wrData;
    end else if (wrSet) begin
      // zero bits leave their enables alone
      mask_d = mask_q | wrData;
    end else if (wrClr) begin
      mask_d = mask_q & ~wrData;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= RST_ENABLE;
    end else begin
      mask_q <= mask_d;
    end
  end

  assign mask = mask_q;

endmodule
`default_nettype wire

// *** rtc_irq_and_event_route_enables.sv ***
// interrupt enables, event-route enables and sticky event status
// assumes event pulses arrive one cycle wide on ref_clk
//
// Summary of operation
// - writing one to irq_enable_set turns that event's interrupt enable on
// - writing one to irq_enable_clear at 0x308 turns that enable off
// - reading set or clear address returns the current interrupt mask
// - event_route_enable at 0x340 is plain read-write routing mask
// - writing one to event_route_set at 0x344 turns routing on
// - writing one to event_route_clear at 0x348 turns routing off
// - direct, set and clear routing registers share one mask
// - six fields: tick, wrap, compare0, compare1, compare2, compare3
// - all enables are zero after reset
// - an unrouted event raises no clock request
`timescale 1ns/1ps
`default_nettype none
module rtc_irq_and_event_route_enables
  import rtc_enable_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DATA_W-1:0] regRdata,
  input wire logic tickEvt,
  input wire logic counterWrapEvt,
  input wire logic [3:0] compareEvt,
  output logic [NUM_EVT-1:0] irqEnableMask,
  output logic [NUM_EVT-1:0] eventRouteMask,
  output logic [NUM_EVT-1:0] routedEvt,
  output logic clockRequest,
  output logic irq
);

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [DATA_W-1:0] widen(input logic [NUM_EVT-1:0] v);
    // reserved bits above the six fields always read zero
    widen = {{(DATA_W-NUM_EVT){1'b0}}, v};
  endfunction

  logic [NUM_EVT-1:0] evtIn;
  logic [NUM_EVT-1:0] wrField;
  logic [NUM_EVT-1:0] irqMask;
  logic [NUM_EVT-1:0] routeMask;
  logic [NUM_EVT-1:0] status_q;
  logic [NUM_EVT-1:0] status_d;
  logic [NUM_EVT-1:0] routed_q;
  logic clkReq_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic wrIrqSet;
  logic wrIrqClr;
  logic wrRouteDir;
  logic wrRouteSet;
  logic wrRouteClr;
  logic wrStatus;
  logic regHit;

  // field order fixed: tick, wrap, then the four compares
  assign evtIn[FLD_TICK] = tickEvt;
  assign evtIn[FLD_COUNTER_WRAP] = counterWrapEvt;
  assign evtIn[FLD_COMPARE0] = compareEvt[0];
  assign evtIn[FLD_COMPARE1] = compareEvt[1];
  assign evtIn[FLD_COMPARE2] = compareEvt[2];
  assign evtIn[FLD_COMPARE3] = compareEvt[3];

  // only bits 0..5 of write data are looked at
  assign wrField = regWdata[NUM_EVT-1:0];

  assign wrIrqSet = regWrite && hit(regAddr, OFS_IRQ_ENABLE_SET);
  assign wrIrqClr = regWrite && hit(regAddr, OFS_IRQ_ENABLE_CLEAR);
  assign wrRouteDir = regWrite && hit(regAddr, OFS_EVENT_ROUTE_ENABLE);
  assign wrRouteSet = regWrite && hit(regAddr, OFS_EVENT_ROUTE_SET);
  assign wrRouteClr = regWrite && hit(regAddr, OFS_EVENT_ROUTE_CLEAR);
  assign wrStatus = regWrite && hit(regAddr, OFS_EVENT_STATUS);

  // any mapped address, only the unmapped-access checks read this
  assign regHit = hit(regAddr, OFS_IRQ_ENABLE_SET) ||
                  hit(regAddr, OFS_IRQ_ENABLE_CLEAR) ||
                  hit(regAddr, OFS_EVENT_ROUTE_ENABLE) ||
                  hit(regAddr, OFS_EVENT_ROUTE_SET) ||
                  hit(regAddr, OFS_EVENT_ROUTE_CLEAR) ||
                  hit(regAddr, OFS_EVENT_STATUS);

  // interrupt enables have no direct-write address
  enable_bank irqBank (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wrDirect(1'b0),
    .wrSet(wrIrqSet),
    .wrClr(wrIrqClr),
    .wrData(wrField),
    .mask(irqMask)
  );

  // all three routing addresses land on this single mask
  enable_bank routeBank (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wrDirect(wrRouteDir),
    .wrSet(wrRouteSet),
    .wrClr(wrRouteClr),
    .wrData(wrField),
    .mask(routeMask)
  );

  // sticky status, a new event beats a write-one-to-clear in the same cycle
  always_comb begin
    status_d = (status_q & ~(wrStatus ? wrField : RST_STATUS)) | evtIn;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= RST_STATUS;
    end else begin
      status_q <= status_d;
    end
  end

  // routing and clock request: masked events never wake the fast clocks
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      routed_q <= RST_ENABLE;
      clkReq_q <= 1'b0;
    end else begin
      routed_q <= evtIn & routeMask;
      clkReq_q <= |(evtIn & routeMask);
    end
  end

  // read data stands only in the cycle after the read strobe
  always_comb begin
    rdata_d = RD_UNMAPPED;
    if (regRead) begin
      case (regAddr)
        OFS_IRQ_ENABLE_SET: rdata_d = widen(irqMask);
        OFS_IRQ_ENABLE_CLEAR: rdata_d = widen(irqMask);
        OFS_EVENT_ROUTE_ENABLE: rdata_d = widen(routeMask);
        OFS_EVENT_ROUTE_SET: rdata_d = widen(routeMask);
        OFS_EVENT_ROUTE_CLEAR: rdata_d = widen(routeMask);
        OFS_EVENT_STATUS: rdata_d = widen(status_q);
        default: rdata_d = RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= RD_UNMAPPED;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign regRdata = rdata_q;
  assign irqEnableMask = irqMask;
  assign eventRouteMask = routeMask;
  assign routedEvt = routed_q;
  assign clockRequest = clkReq_q;
  // level interrupt straight from flops, no extra latency
  assign irq = |(status_q & irqMask);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------

  chk_irq_set_on:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrIrqSet |=> ((irqMask & $past(wrField)) == $past(wrField)))
  else $error("interrupt enable set write did not take effect");

  chk_irq_clr_off:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (regWrite && regAddr == OFS_IRQ_ENABLE_CLEAR) |=>
      ((irqMask & $past(wrField)) == 6'h00))
  else $error("interrupt enable clear write left a bit on");

  chk_irq_readback:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (regRead && (regAddr == OFS_IRQ_ENABLE_SET ||
                 regAddr == OFS_IRQ_ENABLE_CLEAR))
      |=> (regRdata == widen($past(irqMask))))
  else $error("interrupt mask readback mismatch");

  chk_route_direct:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (regWrite && regAddr == OFS_EVENT_ROUTE_ENABLE) |=>
      (routeMask == $past(wrField)))
  else $error("direct routing write not stored");

  chk_route_set_on:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (regWrite && regAddr == OFS_EVENT_ROUTE_SET) |=>
      (routeMask == ($past(routeMask) | $past(wrField))))
  else $error("routing set write wrong");

  chk_route_clr_off:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (regWrite && regAddr == OFS_EVENT_ROUTE_CLEAR) |=>
      (routeMask == ($past(routeMask) & ~$past(wrField))))
  else $error("routing clear write wrong");

  chk_route_shared_read:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (regRead && (regAddr == OFS_EVENT_ROUTE_SET ||
                 regAddr == OFS_EVENT_ROUTE_CLEAR ||
                 regAddr == OFS_EVENT_ROUTE_ENABLE))
      |=> (regRdata == widen($past(routeMask))))
  else $error("routing mask readback mismatch");

  chk_compare3_field:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (compareEvt[3] && routeMask[5]) |=> (routedEvt[5] && clockRequest))
  else $error("compare3 event not routed on bit 5");

  chk_reset_zero:
  assert property (@(posedge ref_clk)
    $rose(rst_n) |-> (irqMask == 6'h00 && routeMask == 6'h00 && !irq))
  else $error("enables not zero after reset");

  chk_no_clock_request:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    ((evtIn & routeMask) == 6'h00) |=> !clockRequest)
  else $error("clock requested by an unrouted event");

  chk_clock_request_on:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    ((evtIn & routeMask) != 6'h00) |=> clockRequest)
  else $error("routed event raised no clock request");

  chk_zero_bits_keep:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wrIrqSet || wrIrqClr) |=>
      ((irqMask & ~$past(wrField)) == ($past(irqMask) & ~$past(wrField))))
  else $error("zero bits of a set or clear write changed the mask");

  chk_reserved_zero:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    regRdata[DATA_W-1:NUM_EVT] == 26'h0000000)
  else $error("reserved read bits not zero");

  chk_status_sticky:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    tickEvt |=> status_q[FLD_TICK] [*2] or
      (status_q[FLD_TICK] ##1 $past(wrStatus)))
  else $error("tick status bit dropped without a clear");

  chk_irq_level:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (tickEvt && irqMask[FLD_TICK] && !wrIrqClr) |=> irq)
  else $error("enabled event raised no interrupt");

  chk_read_one_cycle:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    !regRead |=> (regRdata == RD_UNMAPPED))
  else $error("read data present without a read");

  chk_route_zero_bits:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wrRouteSet || wrRouteClr) |=>
      ((routeMask & ~$past(wrField)) ==
       ($past(routeMask) & ~$past(wrField))))
  else $error("zero bits of a routing set or clear write changed the mask");

  chk_irq_mask_hold:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(wrIrqSet || wrIrqClr) |=> $stable(irqMask))
  else $error("interrupt mask changed without a write to it");

  chk_route_mask_hold:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(wrRouteDir || wrRouteSet || wrRouteClr) |=> $stable(routeMask))
  else $error("routing mask changed without a write to it");

  chk_routed_only_enabled:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (routedEvt & ~($past(evtIn) & $past(routeMask))) == 6'h00)
  else $error("routed output without a routed event");

  chk_tick_blocked:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (tickEvt && !routeMask[FLD_TICK]) |=> !routedEvt[FLD_TICK])
  else $error("unrouted tick reached the routed output");

  chk_wrap_field:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (counterWrapEvt && routeMask[FLD_COUNTER_WRAP]) |=>
      routedEvt[FLD_COUNTER_WRAP])
  else $error("wrap event not routed on its own bit");

  chk_reset_outputs:
  assert property (@(posedge ref_clk)
    $rose(rst_n) |-> (regRdata == RD_UNMAPPED && routedEvt == 6'h00 &&
                      !clockRequest))
  else $error("outputs not idle after reset");

  chk_irq_all_masked:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wrIrqClr && ((irqMask & ~wrField) == 6'h00)) |=> !irq)
  else $error("interrupt stayed high with every enable cleared");

  chk_irq_set_raise:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wrIrqSet && ((wrField & status_q) != 6'h00)) |=> irq)
  else $error("enabling a pending source raised no interrupt");

  chk_unmapped_read:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (regRead && !regHit) |=> (regRdata == RD_UNMAPPED))
  else $error("unmapped read returned data");

  chk_unmapped_write:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (regWrite && !regHit) |=> ($stable(irqMask) && $stable(routeMask)))
  else $error("unmapped write changed an enable mask");

  chk_status_readback:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (regRead && regAddr == OFS_EVENT_STATUS) |=>
      (regRdata == widen($past(status_q))))
  else $error("status readback mismatch");

  chk_status_clear:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wrStatus && wrField[FLD_TICK] && !tickEvt) |=> !status_q[FLD_TICK])
  else $error("tick status bit survived its clear");

  chk_status_set_wins:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wrStatus && wrField[FLD_TICK] && tickEvt) |=> status_q[FLD_TICK])
  else $error("clear beat a tick in the same cycle");

  chk_status_hold:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    !wrStatus |=> ((status_q & $past(status_q)) == $past(status_q)))
  else $error("status bit dropped without a clear");

  chk_status_only_events:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (status_q & ~$past(status_q) & ~$past(evtIn)) == 6'h00)
  else $error("status bit set without an event");

  chk_status_irq_clear:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wrStatus && ((status_q & ~wrField & irqMask) == 6'h00) &&
     ((evtIn & irqMask) == 6'h00)) |=> !irq)
  else $error("interrupt stayed high after its status was cleared");

endmodule
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the counter's interrupt and route enable registers
// assumes the design answers reads one cycle after the strobe, never stalls
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin nChecks++; if ((a) !== (e)) begin nMismatch++; \
  $display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
  import rtc_enable_pkg::*;
  logic ref_clk;
  logic rst_n;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata;
  logic regWrite;
  logic regRead;
  logic [DATA_W-1:0] regRdata;
  logic [NUM_EVT-1:0] evt;
  logic [NUM_EVT-1:0] irqEnableMask;
  logic [NUM_EVT-1:0] eventRouteMask;
  logic [NUM_EVT-1:0] routedEvt;
  logic clockRequest;
  logic irq;
  logic [NUM_EVT-1:0] irqM;
  logic [NUM_EVT-1:0] rteM;
  int nMismatch = 0;
  int nChecks = 0;

  rtc_irq_and_event_route_enables i_rtc_irq_and_event_route_enables (
    .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .tickEvt(evt[0]), .counterWrapEvt(evt[1]),
    .compareEvt(evt[5:2]), .irqEnableMask(irqEnableMask),
    .eventRouteMask(eventRouteMask), .routedEvt(routedEvt),
    .clockRequest(clockRequest), .irq(irq));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    #1;
    `CHK(irqEnableMask, irqM)
    `CHK(eventRouteMask, rteM)
  endtask

  // read data must stand in the cycle after the strobe and only there
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1;
    `CHK(regRdata, e)
    @(posedge ref_clk);
    #1;
    `CHK(regRdata, 32'h0000_0000)
  endtask

  task automatic pulse(input int i);
    logic [NUM_EVT-1:0] e;
    e = rteM & (6'h01 << i);
    @(posedge ref_clk);
    evt <= 6'h01 << i;
    @(posedge ref_clk);
    evt <= 6'h00;
    #1;
    `CHK(routedEvt, e)
    `CHK(clockRequest, |e)
    @(posedge ref_clk);
    #1;
    `CHK(routedEvt, 6'h00)
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", nChecks, nMismatch);
    if (nMismatch == 0 && nChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk);
    nMismatch++;
    finish_test();
  end

  initial begin
    logic [ADDR_W-1:0] adr [7];
    adr = '{OFS_IRQ_ENABLE_SET, OFS_IRQ_ENABLE_CLEAR, OFS_EVENT_ROUTE_ENABLE,
      OFS_EVENT_ROUTE_SET, OFS_EVENT_ROUTE_CLEAR, OFS_EVENT_STATUS, 12'h30c};
    rst_n = 1'b0;
    regAddr = '0;
    regWdata = '0;
    regWrite = 1'b0;
    regRead = 1'b0;
    evt = '0;
    irqM = '0;
    rteM = '0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) rd(adr[i], 32'h0000_0000);
    for (int i = 0; i < NUM_EVT; i++) begin
      irqM[i] = 1'b1;
      wr(OFS_IRQ_ENABLE_SET, 32'h1 << i);
      rd(OFS_IRQ_ENABLE_SET, {26'h0, irqM});
      rd(OFS_IRQ_ENABLE_CLEAR, {26'h0, irqM});
    end
    wr(OFS_IRQ_ENABLE_SET, 32'h0);
    wr(OFS_IRQ_ENABLE_CLEAR, 32'h0);
    irqM = 6'h1b;
    wr(OFS_IRQ_ENABLE_CLEAR, 32'h24);
    rd(OFS_IRQ_ENABLE_CLEAR, 32'h1b);
    wr(OFS_IRQ_ENABLE_SET, 32'hffff_ffc0);
    rd(OFS_IRQ_ENABLE_SET, 32'h1b);
    rteM = 6'h15;
    wr(OFS_EVENT_ROUTE_ENABLE, 32'hffff_ff15);
    rd(OFS_EVENT_ROUTE_ENABLE, 32'h15);
    rd(OFS_EVENT_ROUTE_SET, 32'h15);
    rd(OFS_EVENT_ROUTE_CLEAR, 32'h15);
    rteM = 6'h37;
    wr(OFS_EVENT_ROUTE_SET, 32'h22);
    rteM = 6'h32;
    wr(OFS_EVENT_ROUTE_CLEAR, 32'h05);
    wr(OFS_EVENT_ROUTE_CLEAR, 32'h0);
    rd(OFS_EVENT_ROUTE_ENABLE, 32'h32);
    // an unmapped write must leave both masks alone
    wr(12'h30c, 32'hffff_ffff);
    for (int i = 0; i < NUM_EVT; i++) pulse(i);
    `CHK(irq, 1'b1)
    rd(OFS_EVENT_STATUS, 32'h3f);
    // masking every source must drop the line although status stays set
    irqM = 6'h00;
    wr(OFS_IRQ_ENABLE_CLEAR, 32'h3f);
    `CHK(irq, 1'b0)
    irqM = 6'h01;
    wr(OFS_IRQ_ENABLE_SET, 32'h01);
    `CHK(irq, 1'b1)
    wr(OFS_EVENT_STATUS, 32'h01);
    `CHK(irq, 1'b0)
    rd(OFS_EVENT_STATUS, 32'h3e);
    // a tick in the very cycle of its clear must leave the bit set
    @(posedge ref_clk);
    regAddr <= OFS_EVENT_STATUS;
    regWdata <= 32'h0000_0001;
    regWrite <= 1'b1;
    evt <= 6'h01;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    evt <= 6'h00;
    #1;
    `CHK(irq, 1'b1)
    rd(OFS_EVENT_STATUS, 32'h3f);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    irqM = '0;
    rteM = '0;
    #1;
    `CHK(irqEnableMask, 6'h00)
    `CHK(eventRouteMask, 6'h00)
    rd(OFS_EVENT_ROUTE_SET, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
